// [row_chk.sv]
/* checker for row_relay_ctrl: relations between its ports over time.
   assumes one pclk domain; bound by name after the module. */
`timescale 1ns/100ps
module row_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [row_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [1:0] line_sel,
  input wire row_pkg::row_relay_t relay,
  input wire row_pkg::row_ind_t ind,
  input wire logic wd_tripped
);
  import row_pkg::*;
  logic wr_c;
  // a control write commits at this edge
  assign wr_c = psel && penable && pready && pwrite && paddr == ADDR_CTRL;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence wr_s;
    wr_c;
  endsequence
  ////////////////////////////////////////
  // the source drive comes up one edge after reset lifts, so skip that edge
  src_on_a: assert property (ce && !wd_tripped && $past(presetn) |=>
    relay.source || wd_tripped)
    else $error("source off without trip");
  trip_off_a: assert property (wd_tripped |-> relay == '0 && ind[7:1] == '0)
    else $error("output live during trip");
  ind_mirror_a: assert property (ind.wheel_heat_indicator == relay.wheel_heat &&
    ind.bench_heat_indicator == (relay.bench_elem_hi | relay.bench_elem_lo) &&
    ind.source_indicator == relay.source && !ind.spare_indicator)
    else $error("indicator differs from drive");
  valve_ind_a: assert property (ind.sample_cal_valve_indicator == relay.sample_cal &&
    ind.zero_span_valve_indicator == relay.zero_span &&
    ind.shutoff_valve_indicator == relay.shutoff)
    else $error("valve indicator wrong");
  bench_one_a: assert property (!(relay.bench_elem_hi && relay.bench_elem_lo))
    else $error("both bench elements on");
  ready_next_a: assert property (psel && !penable && ce && !pready |=> pready)
    else $error("no ready after setup");
  err_read_a: assert property (pready && paddr != ADDR_CTRL && paddr != ADDR_STATUS
    |-> pslverr && prdata == RDATA_ZERO)
    else $error("unmapped access not refused");
  hb_follow_a: assert property (wr_s |-> ##2 ind.heartbeat_indicator == $past(pwdata[5], 2))
    else $error("heartbeat not as written");
  cmd_apply_a: assert property (wr_s |-> ##2 (wd_tripped ||
    relay[5:3] == $past(pwdata[4:2], 2) && relay.wheel_heat == $past(pwdata[0], 2)))
    else $error("command not applied");
  trip_hold_a: assert property (wd_tripped && !wr_c |=> wd_tripped)
    else $error("trip lifted without write");
endmodule : row_chk
bind row_relay_ctrl row_chk u_row_chk (.pclk, .presetn, .ce, .psel, .penable, .pwrite,
  .paddr, .pwdata, .prdata, .pready, .pslverr, .line_sel, .relay, .ind, .wd_tripped);

// [row_hb_watch.sv]
/*
  heartbeat silence timer: counts cycles since the heartbeat level last
  changed and pulses once when the silence reaches the trip count.
  assumes the heartbeat input is already in the pclk domain.
*/
`timescale 1ns/100ps
module row_hb_watch #(
  parameter logic [row_pkg::WD_CNT_W-1:0] TRIP_CYC = row_pkg::WD_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic heartbeat,
  output logic expire
);
  import row_pkg::*;

  logic [WD_CNT_W-1:0] cnt_q, cnt_d;
  logic hb_q, hb_d;
  logic changed;

  ////////////////////////////////////////////////////////////////////////////
  // any change restarts the count; the count saturates so the pulse is single
  always_comb
  begin
    changed = heartbeat != hb_q;
    hb_d = heartbeat;
    cnt_d = cnt_q;
    if (changed)
      cnt_d = '0;
    else if (cnt_q != TRIP_CYC)
      cnt_d = cnt_q + WD_CNT_W'(1);
    // stuck on or stuck off both count the same way
    expire = !changed && (cnt_q == TRIP_CYC - WD_CNT_W'(1));
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cnt_q <= '0;
      hb_q <= 1'b0;
    end
    else if (ce)
    begin
      cnt_q <= cnt_d;
      hb_q <= hb_d;
    end
  end

endmodule : row_hb_watch

// [row_host_bfm.sv]
/* host model: apb master issuing one transfer at a time.
   assumes pready is sampled on rising pclk edges. */
`timescale 1ns/100ps
module row_host_bfm (
  input wire logic pclk,
  output logic psel,
  output logic penable,
  output logic pwrite,
  output logic [row_pkg::ADDR_W-1:0] paddr,
  output logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr
);
  import row_pkg::*;
  initial {psel, penable, pwrite, paddr, pwdata} = '0;
  ////////////////////////////////////////
  // released address and data go inverse so stale values never look valid
  task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [31:0] d,
    output logic [31:0] rd, output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    paddr <= ~a;
    pwdata <= ~d;
  endtask : xfer
endmodule : row_host_bfm

// [row_pkg.sv]
/*
  shared definitions for the relay output watchdog: register offsets, field
  layouts, reset values, line voltage encodings and watchdog timing.
  assumes a single 200 MHz clock domain and a 32-bit APB register bus.
*/
package row_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // clock and timing
  localparam longint unsigned CLK_HZ = 200_000_000;
  // heartbeat period the host keeps to; the block itself only needs the trip time
  localparam longint unsigned HB_PERIOD_S = 3;
  localparam longint unsigned WD_TIMEOUT_S = 30;
  localparam int WD_CNT_W = 33;
  // a longest-silence figure: whole seconds, so the product is exact
  localparam logic [WD_CNT_W-1:0] WD_TIMEOUT_CYC = WD_CNT_W'(WD_TIMEOUT_S * CLK_HZ);

  ////////////////////////////////////////////////////////////////////////////
  // register map
  localparam int ADDR_W = 12;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 12'h000;
  localparam logic [ADDR_W-1:0] ADDR_STATUS = 12'h004;
  localparam logic [31:0] RDATA_ZERO = 32'h00000000;

  // control word, low bits of the control register
  typedef struct packed {
    logic heartbeat;
    logic shutoff;
    logic zero_span;
    logic sample_cal;
    logic bench_heat;
    logic wheel_heat;
  } row_ctrl_t;
  localparam int CTRL_W = 6;
  localparam row_ctrl_t CTRL_RST = '0;

  // status word field positions
  localparam int STAT_RELAY_POS = 0;
  localparam int STAT_TRIP_POS = 7;
  localparam int STAT_LINE_POS = 8;

  ////////////////////////////////////////////////////////////////////////////
  // line voltage strap encoding
  typedef enum logic [1:0] {
    ROW_LINE_100 = 2'h0,
    ROW_LINE_115 = 2'h1,
    ROW_LINE_230 = 2'h2
  } row_line_t;
  localparam logic [1:0] LINE_RST = 2'h0;

  // relay and switch drives
  typedef struct packed {
    logic source;
    logic shutoff;
    logic zero_span;
    logic sample_cal;
    logic bench_elem_hi;
    logic bench_elem_lo;
    logic wheel_heat;
  } row_relay_t;
  localparam int RELAY_W = 7;
  localparam row_relay_t RELAY_RST = '0;

  // status indicators, bit 0 is the heartbeat
  typedef struct packed {
    logic source_indicator;
    logic shutoff_valve_indicator;
    logic zero_span_valve_indicator;
    logic sample_cal_valve_indicator;
    logic spare_indicator;
    logic bench_heat_indicator;
    logic wheel_heat_indicator;
    logic heartbeat_indicator;
  } row_ind_t;
  localparam row_ind_t IND_RST = '0;

endpackage : row_pkg

// [row_relay_ctrl.sv]
/*
  relay output controller with heartbeat watchdog. software writes the
  control word over APB; the block drives heater, valve and source relays,
  mirrors them on six of the eight indicators and forces the safety outputs off when
  the heartbeat falls silent.
  assumes a 200 MHz pclk, an APB master in the same domain and a line
  voltage strap that is asynchronous to pclk.
*/
// Local design decisions: the register addresses and the APB slave port.
`timescale 1ns/100ps
module row_relay_ctrl #(
  parameter logic [row_pkg::WD_CNT_W-1:0] WD_TRIP_CYC = row_pkg::WD_TIMEOUT_CYC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [row_pkg::ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [1:0] line_sel,
  output row_pkg::row_relay_t relay,
  output row_pkg::row_ind_t ind,
  output logic wd_tripped
);
  import row_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // register map, one aligned word each
  //   control word, read and write:
  //     bit 0     wheel heater on
  //     bit 1     bench heater on; the strap picks the element
  //     bit 2     sample/cal valve to cal gas
  //     bit 3     zero/span valve to span gas
  //     bit 4     shutoff valve, cal flow open
  //     bit 5     heartbeat level; every flip restarts the silence timer
  //     others    read as zero
  //   status word, read only:
  //     bits 6:0  relay drives, packed as on the relay port
  //     bit 7     watchdog shutdown in force
  //     bits 9:8  synchronised line voltage code
  //   any other offset answers with an error and reads as zero

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [1:0] line_meta_q, line_meta_d;
  logic [1:0] line_q, line_d;

  logic ready_q, ready_d;
  logic [31:0] rdata_q, rdata_d;
  logic slverr_q, slverr_d;
  logic access;
  logic wr_commit;
  logic addr_ok;
  logic [31:0] ctrl_word;
  logic [31:0] stat_word;

  row_ctrl_t ctrl_q, ctrl_d;
  row_ctrl_t wr_ctrl;
  logic trip_q, trip_d;
  logic expire;
  logic hb_toggle;

  row_relay_t relay_q, relay_d;
  row_ind_t ind_q, ind_d;

  ////////////////////////////////////////////////////////////////////////////
  // line voltage strap synchroniser
  // the strap may be moved with power on; two stages keep metastability out

  always_comb
  begin
    line_meta_d = line_sel;
    line_d = line_meta_q;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      line_meta_q <= LINE_RST;
      line_q <= LINE_RST;
    end
    else if (ce)
    begin
      line_meta_q <= line_meta_d;
      line_q <= line_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read words, assembled apart from the bus logic so that the status
  // layout sits in one place

  always_comb
  begin
    ctrl_word = RDATA_ZERO;
    ctrl_word[CTRL_W-1:0] = ctrl_q;
    stat_word = RDATA_ZERO;
    stat_word[STAT_RELAY_POS +: RELAY_W] = relay_q;
    stat_word[STAT_TRIP_POS] = trip_q;
    stat_word[STAT_LINE_POS +: 2] = line_q;
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb slave
  // no wait state: ready rises in the first access cycle, read data is
  // captured on the same edge so it is a clean flop output
  // an unmapped offset gets an error and zero data; a write to the
  // read-only status word is dropped without an error

  always_comb
  begin
    addr_ok = (paddr == ADDR_CTRL) || (paddr == ADDR_STATUS);
    access = psel && !ready_q;
    ready_d = access;
    rdata_d = rdata_q;
    slverr_d = slverr_q;
    if (access)
    begin
      rdata_d = RDATA_ZERO;
      slverr_d = !addr_ok;
      if (!pwrite && paddr == ADDR_CTRL)
        rdata_d = ctrl_word;
      else if (!pwrite && paddr == ADDR_STATUS)
        rdata_d = stat_word;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ready_q <= 1'b0;
      rdata_q <= RDATA_ZERO;
      slverr_q <= 1'b0;
    end
    else if (ce)
    begin
      ready_q <= ready_d;
      rdata_q <= rdata_d;
      slverr_q <= slverr_d;
    end
  end

  // gating ready with ce keeps the master from completing on a frozen edge
  assign pready = ready_q && ce;
  assign prdata = rdata_q;
  assign pslverr = slverr_q && ready_q;

  // a write lands only on the completing edge, and never to a bad address
  assign wr_commit = psel && penable && ready_q && pwrite && (paddr == ADDR_CTRL);

  ////////////////////////////////////////////////////////////////////////////
  // heartbeat silence timer
  // the count restarts on the edge after the heartbeat bit flips and the
  // trip lands one edge after the count reaches one below the trip count, so a
  // shutdown follows the last flip by the trip count plus one edge; a host
  // that keeps its nominal beat never comes close

  row_hb_watch #(
    .TRIP_CYC(WD_TRIP_CYC)
  ) u_hb_watch (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .heartbeat(ctrl_q.heartbeat),
    .expire(expire)
  );

  ////////////////////////////////////////////////////////////////////////////
  // control word and watchdog trip
  // a trip clears the stored commands so a later clear cannot revive stale
  // settings; only a write that also flips the heartbeat lifts the trip

  always_comb
  begin
    wr_ctrl = row_ctrl_t'(pwdata[CTRL_W-1:0]);
    hb_toggle = wr_commit && (wr_ctrl.heartbeat != ctrl_q.heartbeat);
    ctrl_d = ctrl_q;
    trip_d = trip_q;
    if (wr_commit)
      ctrl_d = wr_ctrl;
    if (hb_toggle)
      trip_d = 1'b0;
    // set wins over the clear if both fall on one edge
    if (expire)
    begin
      trip_d = 1'b1;
      ctrl_d.wheel_heat = 1'b0;
      ctrl_d.bench_heat = 1'b0;
      ctrl_d.sample_cal = 1'b0;
      ctrl_d.zero_span = 1'b0;
      ctrl_d.shutoff = 1'b0;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ctrl_q <= CTRL_RST;
      trip_q <= 1'b0;
    end
    else if (ce)
    begin
      ctrl_q <= ctrl_d;
      trip_q <= trip_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // relay drives
  // everything here is forced off while tripped; the wheel motor supply is
  // not switched by this block at all, so it keeps running through a trip

  always_comb
  begin
    relay_d = RELAY_RST;
    if (!trip_d)
    begin
      relay_d.wheel_heat = ctrl_d.wheel_heat;
      relay_d.sample_cal = ctrl_d.sample_cal;
      relay_d.zero_span = ctrl_d.zero_span;
      relay_d.shutoff = ctrl_d.shutoff;
      relay_d.source = 1'b1;
      // an unused strap code lights neither element rather than guess
      unique case (line_q)
        ROW_LINE_100, ROW_LINE_115:
          relay_d.bench_elem_lo = ctrl_d.bench_heat;
        ROW_LINE_230:
          relay_d.bench_elem_hi = ctrl_d.bench_heat;
        default:
        begin
          relay_d.bench_elem_lo = 1'b0;
          relay_d.bench_elem_hi = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      relay_q <= RELAY_RST;
    end
    else if (ce)
    begin
      relay_q <= relay_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // indicators mirror the registered drives, so a lamp never lies about
  // the relay it stands for

  always_comb
  begin
    ind_d = IND_RST;
    ind_d.heartbeat_indicator = ctrl_d.heartbeat;
    ind_d.wheel_heat_indicator = relay_d.wheel_heat;
    ind_d.bench_heat_indicator = relay_d.bench_elem_lo || relay_d.bench_elem_hi;
    ind_d.spare_indicator = 1'b0;
    ind_d.sample_cal_valve_indicator = relay_d.sample_cal;
    ind_d.zero_span_valve_indicator = relay_d.zero_span;
    ind_d.shutoff_valve_indicator = relay_d.shutoff;
    ind_d.source_indicator = relay_d.source;
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ind_q <= IND_RST;
    end
    else if (ce)
    begin
      ind_q <= ind_d;
    end
  end

  assign relay = relay_q;
  assign ind = ind_q;
  assign wd_tripped = trip_q;

endmodule : row_relay_ctrl

// [tb.sv]
/* bench for row_relay_ctrl: decode, strap, refusal and watchdog tests.
   assumes the host model and checker are compiled first. */
`timescale 1ns/100ps
`define CHK(a, e) begin n_checks++; if ((a) !== (e)) begin failures++; \
  $display("Error %0t: got %h exp %h", $time, a, e); end end
module tb;
  import row_pkg::*;
  localparam int TRIP = 50; // short trip so the run stays brief
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, wd_tripped, err, hb;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [1:0] line_sel;
  row_relay_t relay;
  row_ind_t ind;
  int failures = 0;
  int n_checks = 0;
  row_relay_ctrl #(.WD_TRIP_CYC(WD_CNT_W'(TRIP))) u_row_relay_ctrl (.pclk, .presetn, .ce,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .line_sel,
    .relay, .ind, .wd_tripped);
  row_host_bfm u_host (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
    .pready, .pslverr);
  ////////////////////////////////////////
  task automatic results;
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : results
  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] e);
    u_host.xfer(1'b0, a, 32'h0, rd, err);
    `CHK(rd, e)
  endtask : rdc
  // outputs register on the commit edge itself
  task automatic settle;
    repeat (2) @(posedge pclk);
    #1;
  endtask : settle
  // each keep-alive flips the heartbeat and restates the outputs
  task automatic beat(input logic [4:0] v);
    hb = !hb;
    u_host.xfer(1'b1, ADDR_CTRL, {26'h0, hb, v}, rd, err);
  endtask : beat
  initial begin
    pclk = 0;
    forever #2.5 pclk = ~pclk;
  end
  // the whole run is near 400 cycles
  initial begin
    #20000;
    failures++;
    results();
  end
  initial begin
    presetn = 0;
    ce = 1;
    line_sel = ROW_LINE_115;
    hb = 0;
    repeat (8) @(posedge pclk);
    presetn <= 1;
    settle();
    rdc(ADDR_CTRL, 32'h0);
    rdc(ADDR_STATUS, 32'h140);
    beat(5'h1F);
    settle();
    `CHK(relay, 7'h7B)
    `CHK(ind, 8'hF7)
    rdc(ADDR_STATUS, 32'h17B);
    for (int i = 0; i < 4; i++)
    begin
      @(posedge pclk);
      line_sel <= 2'(i);
      repeat (4) @(posedge pclk);
      #1;
      `CHK(relay[2:1], {i == 2, i < 2})
    end
    beat(5'h01);
    settle();
    `CHK(relay, 7'h41)
    `CHK(ind, 8'h82)
    u_host.xfer(1'b0, 12'h008, 32'h0, rd, err);
    `CHK({err, rd}, 33'h100000000)
    u_host.xfer(1'b1, ADDR_STATUS, 32'hFFFFFFFF, rd, err);
    rdc(ADDR_CTRL, 32'h01);
    // keep-alives 43 edges apart hold the trip off; the first follows the
    // last write soon, so no gap reaches the trip count
    repeat (5)
    begin
      beat(5'h01);
      #1;
      `CHK(wd_tripped, 1'b0)
      repeat (40) @(posedge pclk);
    end
    // the trip lands TRIP + 1 edges after the last heartbeat flip
    repeat (TRIP - 40) @(posedge pclk);
    #1;
    `CHK(wd_tripped, 1'b0)
    @(posedge pclk);
    #1;
    `CHK(wd_tripped, 1'b1)
    `CHK(relay, 7'h00)
    `CHK(ind, {7'h00, hb})
    u_host.xfer(1'b1, ADDR_CTRL, {26'h0, hb, 5'h01}, rd, err);
    settle();
    `CHK(relay, 7'h00)
    beat(5'h01);
    settle();
    `CHK(wd_tripped, 1'b0)
    `CHK(relay, 7'h41)
    // a low enable freezes the silence timer, so a pause past the trip
    // count leaves the outputs live
    @(posedge pclk);
    ce <= 1'b0;
    repeat (2 * TRIP) @(posedge pclk);
    #1;
    `CHK(wd_tripped, 1'b0)
    `CHK(relay, 7'h41)
    @(posedge pclk);
    ce <= 1'b1;
    results();
  end
endmodule : tb
